// [src/gpf_ports.sv]
/*
  GPIO logic for ports 4 to 7: data, direction, pull-up and wakeup-select
  registers, read-back merge, pin drive, serial pin sharing on port 4 and
  pin behaviour across power modes.
  Assumes the serial channel control bits, the interrupt-0 select and the
  internal decoder input come from logic on core_clk; pins are asynchronous.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
// Overview of operation
// - Data read: output bits latch, inputs pin
// - Direction one drives pin with data bit
// - Direction registers write-only, read all ones
// - Port 4 data and direction reset F8
// - Port 4 settings only on general pins
// - Pin 1 receives when receive-on set
// - Port 4 reset, standby, retain, run states
// - Port 5 mode bit selects wakeup input
// - Port 5 output only on general pins, pull-up on all
// - Pull-up on when input and enabled
// - Pull-ups off after reset
// - Ports 5, 6 hi-Z, standby pull-up high
// - Ports 5 to 7 registers reset zero
// - Pin 3 internal only, never external
// - Pin 3 plain input or interrupt 0
module gpf_ports (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Register port
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Operating mode
  input  wire gpf_pkg::gpf_pwr_t pwr_mode,
  // Serial channel controls and data
  input  wire logic              ser2_pin_enable,
  input  wire logic              tx_on_bit,
  input  wire logic              rx_on_bit,
  input  wire logic              clock_src_hi,
  input  wire logic              clock_src_lo,
  input  wire logic              sync_mode_sel,
  input  wire logic              ser2_tx_out,
  input  wire logic              ser2_clock_drv,
  output logic                   ser2_rx_in,
  output logic                   ser2_clock_pin,
  // Internal decoder input and interrupt 0
  input  wire logic              int0_pin_sel,
  input  wire logic              p4_internal_in,
  output logic                   int0_n,
  // Port 4 pins 2..0
  input  wire logic [2:0]        p4_in,
  output logic      [2:0]        p4_out,
  output logic      [2:0]        p4_oe,
  // Port 5 pins
  input  wire logic [7:0]        p5_in,
  output logic      [7:0]        p5_out,
  output logic      [7:0]        p5_oe,
  output logic      [7:0]        p5_pullup_on,
  output logic      [7:0]        wakeup_input,
  // Port 6 pins
  input  wire logic [7:0]        p6_in,
  output logic      [7:0]        p6_out,
  output logic      [7:0]        p6_oe,
  output logic      [7:0]        p6_pullup_on,
  // Port 7 pins
  input  wire logic [7:0]        p7_in,
  output logic      [7:0]        p7_out,
  output logic      [7:0]        p7_oe
);

  // Merge latched data and live pin level by direction
  function automatic logic [7:0] rd_mix(input logic [7:0] dir,
                                        input logic [7:0] data,
                                        input logic [7:0] pin);
    rd_mix = (dir & data) | (~dir & pin);
  endfunction : rd_mix

  // Synchronised pins
  logic [gpf_pkg::SYNC_W-1:0] pin_s;        // All pin levels after two flops
  logic [2:0]                 p4_s;         // Port 4 pin levels
  logic [7:0]                 p5_s;         // Port 5 pin levels
  logic [7:0]                 p6_s;         // Port 6 pin levels
  logic [7:0]                 p7_s;         // Port 7 pin levels

  // Software registers
  logic [2:0] p4_data_q, p4_data_d;         // Port 4 data, pins 2..0
  logic [2:0] p4_dir_q,  p4_dir_d;          // Port 4 direction, pins 2..0
  logic [7:0] p5_data_q, p5_data_d;         // Port 5 data
  logic [7:0] p5_dir_q,  p5_dir_d;          // Port 5 direction
  logic [7:0] p5_pu_q,   p5_pu_d;           // Port 5 pull-up enables
  logic [7:0] p5_wake_q, p5_wake_d;         // Port 5 wakeup select
  logic [7:0] p6_data_q, p6_data_d;         // Port 6 data
  logic [7:0] p6_dir_q,  p6_dir_d;          // Port 6 direction
  logic [7:0] p6_pu_q,   p6_pu_d;           // Port 6 pull-up enables
  logic [7:0] p7_data_q, p7_data_d;         // Port 7 data
  logic [7:0] p7_dir_q,  p7_dir_d;          // Port 7 direction

  // Read path
  logic [7:0] rdata_q, rdata_d;             // Read data, valid one cycle
  logic [7:0] p4_view;                      // Port 4 as software sees it

  // Pin drive next values
  logic [2:0] p4_out_d, p4_oe_d;
  logic [7:0] p5_out_d, p5_oe_d, p5_pu_on_d;
  logic [7:0] p6_out_d, p6_oe_d, p6_pu_on_d;
  logic [7:0] p7_out_d, p7_oe_d;
  logic       rx_d, sck_d, int0_d;
  logic [7:0] wake_d;
  logic       run_mode;                     // Active or subactive
  logic       stby_mode;                    // Standby

  // Pin levels pass two flops before any logic reads them
  gpf_sync #(
    .WIDTH    (gpf_pkg::SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({p7_in, p6_in, p5_in, p4_in}),
    .sync_out (pin_s)
  );

  assign p4_s = pin_s[gpf_pkg::S_P4 +: 3];
  assign p5_s = pin_s[gpf_pkg::S_P5 +: 8];
  assign p6_s = pin_s[gpf_pkg::S_P6 +: 8];
  assign p7_s = pin_s[gpf_pkg::S_P7 +: 8];

  // Register writes; every register keeps its value otherwise
  always_comb begin
    p4_data_d = p4_data_q;
    p4_dir_d  = p4_dir_q;
    p5_data_d = p5_data_q;
    p5_dir_d  = p5_dir_q;
    p5_pu_d   = p5_pu_q;
    p5_wake_d = p5_wake_q;
    p6_data_d = p6_data_q;
    p6_dir_d  = p6_dir_q;
    p6_pu_d   = p6_pu_q;
    p7_data_d = p7_data_q;
    p7_dir_d  = p7_dir_q;
    if (reg_wr) begin
      unique case (reg_addr)
        // Upper port 4 bits and bit 3 have no storage
        gpf_pkg::A_P4_DATA: p4_data_d = reg_wdata[2:0];
        gpf_pkg::A_P4_DIR:  p4_dir_d  = reg_wdata[2:0];
        gpf_pkg::A_P5_DATA: p5_data_d = reg_wdata;
        gpf_pkg::A_P5_DIR:  p5_dir_d  = reg_wdata;
        gpf_pkg::A_P5_PU:   p5_pu_d   = reg_wdata;
        gpf_pkg::A_P5_WAKE: p5_wake_d = reg_wdata;
        gpf_pkg::A_P6_DATA: p6_data_d = reg_wdata;
        gpf_pkg::A_P6_DIR:  p6_dir_d  = reg_wdata;
        gpf_pkg::A_P6_PU:   p6_pu_d   = reg_wdata;
        gpf_pkg::A_P7_DATA: p7_data_d = reg_wdata;
        gpf_pkg::A_P7_DIR:  p7_dir_d  = reg_wdata;
        // Unmapped writes are dropped
        default: begin
        end
      endcase
    end
  end

  // Register storage with documented reset values
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      p4_data_q <= gpf_pkg::P4_RESET[2:0];
      p4_dir_q  <= gpf_pkg::P4_RESET[2:0];
      p5_data_q <= gpf_pkg::PX_RESET;
      p5_dir_q  <= gpf_pkg::PX_RESET;
      p5_pu_q   <= gpf_pkg::PX_RESET;
      p5_wake_q <= gpf_pkg::PX_RESET;
      p6_data_q <= gpf_pkg::PX_RESET;
      p6_dir_q  <= gpf_pkg::PX_RESET;
      p6_pu_q   <= gpf_pkg::PX_RESET;
      p7_data_q <= gpf_pkg::PX_RESET;
      p7_dir_q  <= gpf_pkg::PX_RESET;
    end else begin
      p4_data_q <= p4_data_d;
      p4_dir_q  <= p4_dir_d;
      p5_data_q <= p5_data_d;
      p5_dir_q  <= p5_dir_d;
      p5_pu_q   <= p5_pu_d;
      p5_wake_q <= p5_wake_d;
      p6_data_q <= p6_data_d;
      p6_dir_q  <= p6_dir_d;
      p6_pu_q   <= p6_pu_d;
      p7_data_q <= p7_data_d;
      p7_dir_q  <= p7_dir_d;
    end
  end

  // Port 4 read view: upper ones, bit 3 from the decoder
  always_comb begin
    p4_view = rd_mix({gpf_pkg::P4_RESET[7:3], p4_dir_q},
                     {gpf_pkg::P4_RESET[7:3], p4_data_q},
                     {5'h00, p4_s});
    p4_view[gpf_pkg::P4_INT] = p4_internal_in;
  end

  // Read decode; data stand one cycle after the strobe only
  always_comb begin
    rdata_d = gpf_pkg::NONE_READ;
    if (reg_rd) begin
      unique case (reg_addr)
        gpf_pkg::A_P4_DATA: rdata_d = p4_view;
        gpf_pkg::A_P5_DATA: rdata_d = rd_mix(p5_dir_q & ~p5_wake_q,
                                             p5_data_q, p5_s);
        gpf_pkg::A_P6_DATA: rdata_d = rd_mix(p6_dir_q, p6_data_q, p6_s);
        gpf_pkg::A_P7_DATA: rdata_d = rd_mix(p7_dir_q, p7_data_q, p7_s);
        gpf_pkg::A_P5_PU:   rdata_d = p5_pu_q;
        gpf_pkg::A_P6_PU:   rdata_d = p6_pu_q;
        gpf_pkg::A_P5_WAKE: rdata_d = p5_wake_q;
        // Direction registers hide their contents
        gpf_pkg::A_P4_DIR,
        gpf_pkg::A_P5_DIR,
        gpf_pkg::A_P6_DIR,
        gpf_pkg::A_P7_DIR:  rdata_d = gpf_pkg::DIR_READ;
        default:            rdata_d = gpf_pkg::NONE_READ;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= gpf_pkg::NONE_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pin function, pull-ups and power-mode behaviour
  always_comb begin
    run_mode  = 1'b1;
    stby_mode = 1'b0;
    unique case (pwr_mode)
      gpf_pkg::GPF_ACTIVE,
      gpf_pkg::GPF_SUBACTIVE: run_mode = 1'b1;
      // Pins keep whatever they last showed
      gpf_pkg::GPF_SLEEP,
      gpf_pkg::GPF_SUBSLEEP,
      gpf_pkg::GPF_WATCH:     run_mode = 1'b0;
      gpf_pkg::GPF_STANDBY: begin
        run_mode  = 1'b0;
        stby_mode = 1'b1;
      end
      // Spare codes behave as active
      default:                run_mode = 1'b1;
    endcase

    // Defaults hold every output but the wakeup lines and read data
    p4_out_d   = p4_out;
    p4_oe_d    = p4_oe;
    p5_out_d   = p5_out;
    p5_oe_d    = p5_oe;
    p5_pu_on_d = p5_pullup_on;
    p6_out_d   = p6_out;
    p6_oe_d    = p6_oe;
    p6_pu_on_d = p6_pullup_on;
    p7_out_d   = p7_out;
    p7_oe_d    = p7_oe;
    int0_d     = int0_n;
    rx_d       = ser2_rx_in;
    sck_d      = ser2_clock_pin;

    if (run_mode) begin
      // Port 4 general use first, serial takes pins over below
      p4_out_d = p4_data_q;
      p4_oe_d  = p4_dir_q;
      rx_d     = 1'b1;
      sck_d    = 1'b1;
      if (ser2_pin_enable && tx_on_bit) begin
        p4_out_d[gpf_pkg::P4_TX] = ser2_tx_out;
        p4_oe_d[gpf_pkg::P4_TX]  = 1'b1;
      end
      if (rx_on_bit) begin
        p4_oe_d[gpf_pkg::P4_RX] = 1'b0;
        rx_d                    = p4_s[gpf_pkg::P4_RX];
      end
      // External clock wins over the internal clock choice
      if (clock_src_hi) begin
        p4_oe_d[gpf_pkg::P4_SCK] = 1'b0;
        sck_d                    = p4_s[gpf_pkg::P4_SCK];
      end else if (sync_mode_sel || clock_src_lo) begin
        p4_out_d[gpf_pkg::P4_SCK] = ser2_clock_drv;
        p4_oe_d[gpf_pkg::P4_SCK]  = 1'b1;
      end
      // Pin 3 never reaches a pad; it feeds interrupt 0 and the port 4 read view
      int0_d = int0_pin_sel ? p4_internal_in : 1'b1;

      // Wakeup pins are not driven while running; their pull-up still follows the direction bit
      p5_out_d   = p5_data_q;
      p5_oe_d    = p5_dir_q & ~p5_wake_q;
      p5_pu_on_d = ~p5_dir_q & p5_pu_q;
      p6_out_d   = p6_data_q;
      p6_oe_d    = p6_dir_q;
      p6_pu_on_d = ~p6_dir_q & p6_pu_q;
      // Port 7 has no alternate use and no pull-up
      p7_out_d   = p7_data_q;
      p7_oe_d    = p7_dir_q;
    end else if (stby_mode) begin
      // Float pads; a pulled-up pin is driven high instead
      p4_oe_d    = 3'h0;
      p5_out_d   = p5_pullup_on;
      p5_oe_d    = p5_pullup_on;
      p6_out_d   = p6_pullup_on;
      p6_oe_d    = p6_pullup_on;
      p7_oe_d    = 8'h00;
    end
  end

  // Wakeup lines stay live in every mode so they can end a sleep
  always_comb begin
    wake_d = p5_s | ~p5_wake_q;
  end

  // Pin drive flops; reset floats every pad
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      p4_out       <= 3'h0;
      p4_oe        <= 3'h0;
      p5_out       <= 8'h00;
      p5_oe        <= 8'h00;
      p5_pullup_on <= 8'h00;
      p6_out       <= 8'h00;
      p6_oe        <= 8'h00;
      p6_pullup_on <= 8'h00;
      p7_out       <= 8'h00;
      p7_oe        <= 8'h00;
      int0_n       <= 1'b1;
      ser2_rx_in   <= 1'b1;
      ser2_clock_pin <= 1'b1;
      wakeup_input <= 8'hff;
    end else begin
      p4_out       <= p4_out_d;
      p4_oe        <= p4_oe_d;
      p5_out       <= p5_out_d;
      p5_oe        <= p5_oe_d;
      p5_pullup_on <= p5_pu_on_d;
      p6_out       <= p6_out_d;
      p6_oe        <= p6_oe_d;
      p6_pullup_on <= p6_pu_on_d;
      p7_out       <= p7_out_d;
      p7_oe        <= p7_oe_d;
      int0_n       <= int0_d;
      ser2_rx_in   <= rx_d;
      ser2_clock_pin <= sck_d;
      wakeup_input <= wake_d;
    end
  end

  // Read data straight from its flop
  assign reg_rdata = rdata_q;

endmodule : gpf_ports

// [src/gpf_pkg.sv]
/*
  Shared constants for the port 4 to port 7 GPIO block: register byte
  addresses, reset values, field positions and power-mode codes.
  Assumes a byte-wide register port with 16-bit byte addresses.
*/
package gpf_pkg;

  // Register port widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register byte addresses
  localparam logic [15:0] A_P5_WAKE  = 16'hffcc;  // Port 5 wakeup select
  localparam logic [15:0] A_P4_DATA  = 16'hffd7;  // Port 4 data
  localparam logic [15:0] A_P5_DATA  = 16'hffd8;  // Port 5 data
  localparam logic [15:0] A_P6_DATA  = 16'hffd9;  // Port 6 data
  localparam logic [15:0] A_P7_DATA  = 16'hffda;  // Port 7 data
  localparam logic [15:0] A_P5_PU    = 16'hffe2;  // Port 5 pull-up
  localparam logic [15:0] A_P6_PU    = 16'hffe3;  // Port 6 pull-up
  localparam logic [15:0] A_P4_DIR   = 16'hffe7;  // Port 4 direction
  localparam logic [15:0] A_P5_DIR   = 16'hffe8;  // Port 5 direction
  localparam logic [15:0] A_P6_DIR   = 16'hffe9;  // Port 6 direction
  localparam logic [15:0] A_P7_DIR   = 16'hffea;  // Port 7 direction

  // Reset and read-back values
  localparam logic [7:0] P4_RESET    = 8'hf8;     // Port 4 data and direction
  localparam logic [7:0] PX_RESET    = 8'h00;     // Ports 5 to 7 registers
  localparam logic [7:0] DIR_READ    = 8'hff;     // Write-only read-back
  localparam logic [7:0] NONE_READ   = 8'h00;     // Unmapped address

  // Port 4 layout
  localparam int P4_GP_W   = 3;                   // General pins 2..0
  localparam int P4_SCK    = 0;                   // Serial clock pin
  localparam int P4_RX     = 1;                   // Serial receive pin
  localparam int P4_TX     = 2;                   // Serial transmit pin
  localparam int P4_INT    = 3;                   // Internal input bit

  // Synchronised pin bus: port 4 low, port 7 high
  localparam int SYNC_W    = 27;
  localparam int S_P4      = 0;
  localparam int S_P5      = 3;
  localparam int S_P6      = 11;
  localparam int S_P7      = 19;

  // Operating modes
  typedef enum logic [2:0] {
    GPF_ACTIVE    = 3'h0,
    GPF_SUBACTIVE = 3'h1,
    GPF_SLEEP     = 3'h2,
    GPF_SUBSLEEP  = 3'h3,
    GPF_WATCH     = 3'h4,
    GPF_STANDBY   = 3'h5
  } gpf_pwr_t;

endpackage : gpf_pkg

// [src/gpf_sync.sv]
/*
  Two-flop synchroniser for a bus of independent pin levels.
  Assumes each bit is a slow level; no bus coherence is implied.
*/
`timescale 1ns/1ns
module gpf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage

  // Two stages; the first stage feeds nothing else
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : gpf_sync

// [bench/gpf_chk.sv]
/*
  Checker for the port 4 to 7 GPIO block: pins, serial sharing, read-back.
  Assumes one clock domain and pwr_mode codes 0 to 5 only.
*/
`timescale 1ns/1ns
module gpf_chk (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rstn,
  // Register read side
  input wire logic [15:0]       reg_addr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  // Mode, serial and interrupt side
  input wire gpf_pkg::gpf_pwr_t pwr_mode,
  input wire logic              ser2_pin_enable,
  input wire logic              tx_on_bit,
  input wire logic              rx_on_bit,
  input wire logic              clock_src_hi,
  input wire logic              clock_src_lo,
  input wire logic              sync_mode_sel,
  input wire logic              ser2_tx_out,
  input wire logic              ser2_clock_drv,
  input wire logic              ser2_rx_in,
  input wire logic              int0_pin_sel,
  input wire logic              p4_internal_in,
  input wire logic              int0_n,
  // Pins
  input wire logic [2:0]        p4_out,
  input wire logic [2:0]        p4_oe,
  input wire logic [7:0]        p5_out,
  input wire logic [7:0]        p5_oe,
  input wire logic [7:0]        p5_pullup_on,
  input wire logic [7:0]        p7_out,
  input wire logic [7:0]        p7_oe
);
  logic run;    // Pins follow settings
  logic hold;   // Pins keep their state
  logic dir_rd; // Read of a write-only register
  logic p4_rd;  // Read of port 4 data
  assign run = pwr_mode inside {gpf_pkg::GPF_ACTIVE, gpf_pkg::GPF_SUBACTIVE};
  assign hold = pwr_mode inside {gpf_pkg::GPF_SLEEP, gpf_pkg::GPF_SUBSLEEP, gpf_pkg::GPF_WATCH};
  assign dir_rd = reg_rd && (reg_addr inside {gpf_pkg::A_P4_DIR, gpf_pkg::A_P5_DIR,
                                              gpf_pkg::A_P6_DIR, gpf_pkg::A_P7_DIR});
  assign p4_rd = reg_rd && (reg_addr == gpf_pkg::A_P4_DATA);

  // One clock and one reset for all
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  dir_rd_a: assert property ($past(dir_rd) |-> reg_rdata == 8'hff)
    else $error("direction read not all ones");
  p4_rd_a: assert property ($past(p4_rd) |-> reg_rdata[7:3] == {4'hf, $past(p4_internal_in)})
    else $error("port 4 upper read bits wrong");
  pu_excl_a: assert property ($past(run) |-> (p5_pullup_on & p5_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  stby_a: assert property ($past(pwr_mode) == gpf_pkg::GPF_STANDBY |->
    p4_oe == 3'h0 && p7_oe == 8'h00 && p5_oe == p5_pullup_on && p5_out == p5_pullup_on)
    else $error("standby pin state wrong");
  hold_a: assert property (hold |=> $stable(p7_out) && $stable(p7_oe) && $stable(p5_oe)
    && $stable(p4_oe) && $stable(int0_n))
    else $error("pins moved in a retain mode");
  tx_pin_a: assert property (run && ser2_pin_enable && tx_on_bit |=>
    p4_oe[2] && p4_out[2] == $past(ser2_tx_out))
    else $error("transmit pin not driven");
  rx_pin_a: assert property (run |=> ($past(rx_on_bit) ? !p4_oe[1] : ser2_rx_in))
    else $error("receive pin sharing wrong");
  sck_out_a: assert property (run && !clock_src_hi && (clock_src_lo || sync_mode_sel) |=>
    p4_oe[0] && p4_out[0] == $past(ser2_clock_drv))
    else $error("serial clock not driven");
  sck_in_a: assert property (run && clock_src_hi |=> !p4_oe[0])
    else $error("clock input pin driven");
  int0_a: assert property (run |=> int0_n == ($past(int0_pin_sel) ? $past(p4_internal_in) : 1'b1))
    else $error("interrupt 0 input wrong");
  rst_out_a: assert property ($rose(rstn) |-> p5_pullup_on == 8'h00 && p5_oe == 8'h00
    && p7_oe == 8'h00 && p4_oe == 3'h0 && int0_n)
    else $error("pins not idle after reset");
endmodule : gpf_chk

bind gpf_ports gpf_chk gpf_chk_i (.*);

// [bench/gpf_pins.sv]
/*
  Far-side pin model: each pin level from drive, pull-up, outside level.
  Assumes the bench sets the outside level of undriven pins.
*/
`timescale 1ns/1ns
module gpf_pins (
  // Drive from the block
  input wire logic [2:0]  p4_out,
  input wire logic [2:0]  p4_oe,
  input wire logic [7:0]  p5_out,
  input wire logic [7:0]  p5_oe,
  input wire logic [7:0]  p5_pullup_on,
  input wire logic [7:0]  p6_out,
  input wire logic [7:0]  p6_oe,
  input wire logic [7:0]  p6_pullup_on,
  input wire logic [7:0]  p7_out,
  input wire logic [7:0]  p7_oe,
  // Outside level where nothing drives, port 4 low
  input wire logic [26:0] ext_lvl,
  // Levels seen by the block
  output logic [2:0]      p4_in,
  output logic [7:0]      p5_in,
  output logic [7:0]      p6_in,
  output logic [7:0]      p7_in
);

  // Driver wins, then pull-up, then outside
  function automatic logic [7:0] lvl(input logic [7:0] o, e, u, x);
    return (e & o) | (~e & u) | (~e & ~u & x);
  endfunction : lvl

  assign p4_in = 3'(lvl({5'h00, p4_out}, {5'h00, p4_oe}, 8'h00, {5'h00, ext_lvl[2:0]}));
  assign p5_in = lvl(p5_out, p5_oe, p5_pullup_on, ext_lvl[10:3]);
  assign p6_in = lvl(p6_out, p6_oe, p6_pullup_on, ext_lvl[18:11]);
  assign p7_in = lvl(p7_out, p7_oe, 8'h00, ext_lvl[26:19]);
endmodule : gpf_pins

// [bench/gpf_ports_tb.sv]
/*
  Self-checking bench for gpf_ports with pin model and bound checker.
  Assumes one clock; pins settle within five cycles.
*/
`timescale 1ns/1ns
module gpf_ports_tb;
  // Clock, reset, register port
  logic              core_clk, rstn, reg_wr, reg_rd;
  logic [15:0]       reg_addr;
  logic [7:0]        reg_wdata, reg_rdata;
  gpf_pkg::gpf_pwr_t pwr_mode;
  // Serial and interrupt side
  logic              ser2_pin_enable, tx_on_bit, rx_on_bit, clock_src_hi, clock_src_lo;
  logic              sync_mode_sel, ser2_tx_out, ser2_clock_drv, ser2_rx_in, ser2_clock_pin;
  logic              int0_pin_sel, p4_internal_in, int0_n;
  // Pins and outside levels
  logic [2:0]        p4_in, p4_out, p4_oe;
  logic [7:0]        p5_in, p5_out, p5_oe, p5_pullup_on, wakeup_input;
  logic [7:0]        p6_in, p6_out, p6_oe, p6_pullup_on, p7_in, p7_out, p7_oe;
  logic [26:0]       ext_lvl;
  // Expected registers, index 0 to 3 for ports 4 to 7
  logic [7:0]        dat [4];
  logic [7:0]        dir [4];
  logic [7:0]        pu5, pu6, wk5, v;
  logic [15:0]       dadr [4];
  logic [15:0]       cadr [4];
  integer            errors, comparisons, seed, i;

  gpf_ports gpf_ports_i (.*);
  gpf_pins gpf_pins_i (.*);

  // Free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Expected drive; serial functions assumed off
  function automatic logic [7:0] oe_exp(input int p);
    return dir[p] & ((p == 0) ? 8'h07 : 8'hff) & ((p == 1) ? ~wk5 : 8'hff);
  endfunction : oe_exp
  function automatic logic [7:0] pu_exp(input int p);
    return (p == 1) ? (~dir[1] & pu5) : (p == 2) ? (~dir[2] & pu6) : 8'h00;
  endfunction : pu_exp
  // Pin level; a driven pin reads its data bit
  function automatic logic [7:0] lvl_exp(input int p);
    logic [7:0] e, u, x;
    e = oe_exp(p);
    u = pu_exp(p);
    x = {5'h00, ext_lvl[2:0]};
    if (p > 0) x = ext_lvl[8*p-5 +: 8];
    return (e & dat[p]) | (~e & u) | (~e & ~u & x);
  endfunction : lvl_exp
  function automatic logic [7:0] rd_exp(input int p);
    logic [7:0] r;
    r = lvl_exp(p);
    if (p == 0) r[7:3] = {4'hf, p4_internal_in};
    return r;
  endfunction : rd_exp

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bus write; shadow updated when the design takes it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (a == dadr[k]) dat[k] = d;
      if (a == cadr[k]) dir[k] = d;
    end
    if (a == gpf_pkg::A_P5_PU) pu5 = d;
    if (a == gpf_pkg::A_P6_PU) pu6 = d;
    if (a == gpf_pkg::A_P5_WAKE) wk5 = d;
  endtask : wr

  // Bus read; data stands one cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd

  task automatic rd_chk(input int p);
    rd(dadr[p], v);
    chk(v, rd_exp(p));
    rd(cadr[p], v);
    chk(v, 8'hff);
  endtask : rd_chk

  task automatic cfg_chk();
    rd(gpf_pkg::A_P5_PU, v);
    chk(v, pu5);
    rd(gpf_pkg::A_P6_PU, v);
    chk(v, pu6);
    rd(gpf_pkg::A_P5_WAKE, v);
    chk(v, wk5);
    rd(16'hffd0, v);
    chk(v, 8'h00);
  endtask : cfg_chk

  task automatic pins_chk();
    chk({5'h00, p4_oe}, oe_exp(0));
    chk(p5_oe, oe_exp(1));
    chk(p6_oe, oe_exp(2));
    chk(p7_oe, oe_exp(3));
    chk(p7_out & p7_oe, dat[3] & oe_exp(3));
    chk(p6_out & p6_oe, dat[2] & oe_exp(2));
    chk(p5_pullup_on, pu_exp(1));
    chk(p6_pullup_on, pu_exp(2));
    chk(wakeup_input, ~wk5 | lvl_exp(1));
  endtask : pins_chk

  // Serial sharing of port 4 pins 2 to 0
  task automatic ser_chk();
    logic tx, ck;
    logic [7:0] e;
    tx = ser2_pin_enable & tx_on_bit;
    ck = ~clock_src_hi & (clock_src_lo | sync_mode_sel);
    e = {5'h00, tx | dir[0][2], ~rx_on_bit & dir[0][1], ~clock_src_hi & (ck | dir[0][0])};
    chk({5'h00, p4_oe}, e);
    chk({6'h00, p4_out[2] & tx, p4_out[0] & ck}, {6'h00, ser2_tx_out & tx, ser2_clock_drv & ck});
    e = {6'h00, ~rx_on_bit | ext_lvl[1], ~clock_src_hi | ext_lvl[0]};
    chk({6'h00, ser2_rx_in, ser2_clock_pin}, e);
  endtask : ser_chk

  // Reset, then reset state of pins and registers
  task automatic rst_chk();
    rstn <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      dat[k] = (k == 0) ? 8'hf8 : 8'h00;
      dir[k] = dat[k];
    end
    {pu5, pu6, wk5} = '0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge core_clk);
    pins_chk();
    for (int k = 0; k < 4; k++) rd_chk(k);
    cfg_chk();
  endtask : rst_chk

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    final_report();
  end

  // Main sequence
  initial begin
    seed = 64;
    errors = 0;
    comparisons = 0;
    dadr = '{gpf_pkg::A_P4_DATA, gpf_pkg::A_P5_DATA, gpf_pkg::A_P6_DATA, gpf_pkg::A_P7_DATA};
    cadr = '{gpf_pkg::A_P4_DIR, gpf_pkg::A_P5_DIR, gpf_pkg::A_P6_DIR, gpf_pkg::A_P7_DIR};
    {reg_wr, reg_rd, ser2_pin_enable, tx_on_bit, rx_on_bit, clock_src_hi} <= '0;
    {clock_src_lo, sync_mode_sel, ser2_tx_out, ser2_clock_drv, int0_pin_sel} <= '0;
    {reg_addr, reg_wdata, p4_internal_in} <= '0;
    pwr_mode <= gpf_pkg::GPF_ACTIVE;
    ext_lvl <= 27'h5a5a5a5;
    rst_chk();
    // Random writes anywhere, unmapped included
    for (i = 0; i < 60; i++) begin
      v = $random(seed);
      case ({$random(seed)} % 8)
        0, 1: wr(dadr[i % 4], v);
        2, 3: wr(cadr[i % 4], v);
        4: wr(gpf_pkg::A_P5_PU, v);
        5: wr(gpf_pkg::A_P6_PU, v);
        6: wr(gpf_pkg::A_P5_WAKE, v);
        default: wr(16'hffd0, v);
      endcase
      ext_lvl <= 27'($random(seed));
      repeat (5) @(posedge core_clk);
      pins_chk();
      rd_chk(i % 4);
      cfg_chk();
    end
    // Every serial control combination
    v = $random(seed);
    wr(cadr[0], v);
    for (i = 0; i < 64; i++) begin
      {ser2_pin_enable, tx_on_bit, rx_on_bit, clock_src_hi, clock_src_lo, sync_mode_sel} <= i[5:0];
      v = $random(seed);
      {ser2_tx_out, ser2_clock_drv} <= v[1:0];
      ext_lvl <= 27'($random(seed));
      repeat (5) @(posedge core_clk);
      ser_chk();
    end
    {ser2_pin_enable, tx_on_bit, rx_on_bit, clock_src_hi, clock_src_lo, sync_mode_sel} <= '0;
    // Internal input as plain bit and as interrupt 0
    for (i = 0; i < 8; i++) begin
      {int0_pin_sel, p4_internal_in} <= i[1:0];
      repeat (3) @(posedge core_clk);
      chk({7'h00, int0_n}, {7'h00, ~int0_pin_sel | p4_internal_in});
      rd_chk(0);
    end
    // Standby with some pull-ups on
    wr(gpf_pkg::A_P5_PU, 8'hff);
    wr(cadr[1], 8'h0f);
    wr(gpf_pkg::A_P6_PU, 8'h3c);
    repeat (2) @(posedge core_clk);
    pwr_mode <= gpf_pkg::GPF_STANDBY;
    repeat (3) @(posedge core_clk);
    chk({5'h00, p4_oe} | p7_oe, 8'h00);
    chk(p5_oe, pu_exp(1));
    chk(p5_out, pu_exp(1));
    chk(p6_oe, pu_exp(2));
    // Sleep, subsleep, watch keep pins while registers change
    for (i = 2; i < 5; i++) begin
      pwr_mode <= gpf_pkg::GPF_ACTIVE;
      wr(cadr[3], 8'hff);
      repeat (3) @(posedge core_clk);
      v = p7_out;
      pwr_mode <= gpf_pkg::gpf_pwr_t'(i);
      wr(dadr[3], ~v);
      repeat (3) @(posedge core_clk);
      chk(p7_out, v);
    end
    pwr_mode <= gpf_pkg::GPF_SUBACTIVE;
    repeat (3) @(posedge core_clk);
    pins_chk();
    pwr_mode <= gpf_pkg::GPF_ACTIVE;
    rst_chk();
    final_report();
  end
endmodule : gpf_ports_tb
